// >>> mpfi_params.svh
`ifndef MPFI_PARAMS_SVH
`define MPFI_PARAMS_SVH
// Transceiver speed select codes
`define MPFI_XCVR_1G 2'h0
`define MPFI_XCVR_2P5G 2'h1
`define MPFI_XCVR_BAD 2'h2
`define MPFI_XCVR_10G 2'h3
// Operating speed report codes
`define MPFI_SPD_10G 3'h0
`define MPFI_SPD_1G 3'h1
`define MPFI_SPD_100M 3'h2
`define MPFI_SPD_10M 3'h3
`define MPFI_SPD_2P5G 3'h4
`define MPFI_SPD_5G 3'h5
// Lane layout
`define MPFI_LO_MSB 7
`define MPFI_HI_LSB 8
`define MPFI_DATA_W 16
`define MPFI_LANES 2
// Path delay fields: whole cycles 21:10, fraction 9:0
`define MPFI_DELAY_W 22
`define MPFI_FRAC_W 10
`define MPFI_WHOLE_LSB 10
// Pipeline depth of the device transmit path in cycles
`define MPFI_PIPE_CYCLES 12'h002
// Interface clock rates in kHz
`define MPFI_GMII_1G_KHZ 62500
`define MPFI_GMII_2P5G_KHZ 156250
`endif

// >>> mpfi_pkg.sv
package mpfi_pkg;
  typedef enum logic [1:0] {MPFI_TX_IDLE = 2'b01, MPFI_TX_FRAME = 2'b10} mpfi_tx_state_e;
  typedef logic [15:0] mpfi_bytes_t;
endpackage

// >>> mpfi_if.sv
`timescale 1ns/100ps
interface mpfi_if;
  // Reset requests and status
  logic tx_analog_reset;
  logic tx_digital_reset;
  logic rx_analog_reset;
  logic rx_digital_reset;
  logic tx_analog_reset_stat;
  logic tx_digital_reset_stat;
  logic rx_analog_reset_stat;
  logic rx_digital_reset_stat;
  // Rate
  logic [1:0] xcvr_speed_sel;
  logic [2:0] operating_speed;
  // Transmit wide GMII
  logic [15:0] wide_tx_bytes;
  logic [1:0] wide_tx_lane_valid;
  logic [1:0] wide_tx_lane_error;
  logic [21:0] wide_tx_path_delay;
  modport device (
    input tx_analog_reset, tx_digital_reset, rx_analog_reset, rx_digital_reset, xcvr_speed_sel,
    input wide_tx_bytes, wide_tx_lane_valid, wide_tx_lane_error,
    output tx_analog_reset_stat, tx_digital_reset_stat, rx_analog_reset_stat, rx_digital_reset_stat,
    output operating_speed, wide_tx_path_delay
  );
  modport host (
    output tx_analog_reset, tx_digital_reset, rx_analog_reset, rx_digital_reset, xcvr_speed_sel,
    output wide_tx_bytes, wide_tx_lane_valid, wide_tx_lane_error,
    input tx_analog_reset_stat, tx_digital_reset_stat, rx_analog_reset_stat, rx_digital_reset_stat,
    input operating_speed, wide_tx_path_delay
  );
endinterface

// >>> mpfi_device.sv
`timescale 1ns/100ps
`include "mpfi_params.svh"
// Overview of operation
// - Global reset initialises all device logic synchronously, on the clock edge
// - Transmit analog reset clears transmit analog part
// - Transmit digital reset clears transmit logic
// - Receive resets clear receive logic and recovery
// - Each reset input has a status output
// - Speed select codes choose 1G, 2.5G, 10G
// - Current rate reported on three-bit code
// - Wide GMII runs 62.5 or 156.25 MHz
// - Transmit GMII synchronous to transmit clock
// - Low byte is earlier, sent first
// - Lane valid bits qualify low, high byte
// - Host holds valid through final byte
// - Lane error marks current frame errored
// - Path delay: whole cycles 21:10, fraction 9:0
module mpfi_device
  import mpfi_pkg::*;
#(
  parameter bit PTP_ENABLE = 1'b1
)
(
  // Clock and global reset
  input wire logic clk,
  input wire logic reset,
  // Link to host
  mpfi_if.device link,
  // Transmit byte stream toward the line
  output logic [7:0] line_byte,
  output logic line_byte_valid,
  output logic line_byte_error,
  output logic line_frame_start,
  output logic line_frame_end,
  // Receive side status
  output logic rx_active
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic tx_an_stat;
    logic tx_dig_stat;
    logic rx_an_stat;
    logic rx_dig_stat;
    logic [2:0] speed;
    mpfi_tx_state_e st;
    logic frame_err;
    logic [7:0] held_byte;
    logic held_valid;
    logic held_err;
    logic [7:0] out_byte;
    logic out_valid;
    logic out_err;
    logic out_start;
    logic out_end;
    logic rx_act;
    logic [21:0] delay;
  } mpfi_dev_s;

  mpfi_dev_s r;
  mpfi_dev_s next_r;
  logic [1:0] vld;
  logic [1:0] err;
  logic any_err;
  // Fixed transmit latency, whole cycles over fraction
  localparam logic [`MPFI_DELAY_W-1:0] PATH_DELAY = PTP_ENABLE ?
    {`MPFI_PIPE_CYCLES, {`MPFI_FRAC_W{1'b0}}} : {`MPFI_DELAY_W{1'b0}};

  ////////////////////////////////////////////////////////////////////////////
  assign vld = link.wide_tx_lane_valid;
  assign err = link.wide_tx_lane_error;
  // Errors count only on lanes that carry a byte
  assign any_err = |(err & vld);

  always_comb
  begin
    next_r = r;
    // Status follows each reset request
    next_r.tx_an_stat = link.tx_analog_reset;
    next_r.tx_dig_stat = link.tx_digital_reset;
    next_r.rx_an_stat = link.rx_analog_reset;
    next_r.rx_dig_stat = link.rx_digital_reset;

    // Unlisted select code leaves the rate alone
    case (link.xcvr_speed_sel)
      `MPFI_XCVR_1G: next_r.speed = `MPFI_SPD_1G;
      `MPFI_XCVR_2P5G: next_r.speed = `MPFI_SPD_2P5G;
      `MPFI_XCVR_10G: next_r.speed = `MPFI_SPD_10G;
      default: next_r.speed = r.speed;
    endcase

    // Line strobes last one cycle unless set below
    next_r.out_valid = 1'b0;
    next_r.out_start = 1'b0;
    next_r.out_end = 1'b0;
    next_r.out_err = 1'b0;

    // Low byte goes now, high byte is held for the next cycle
    case (r.st)
      MPFI_TX_IDLE:
      begin
        next_r.frame_err = 1'b0;
        if (vld[0])
        begin
          next_r.st = MPFI_TX_FRAME;
          next_r.out_byte = link.wide_tx_bytes[`MPFI_LO_MSB:0];
          next_r.out_valid = 1'b1;
          next_r.out_start = 1'b1;
          next_r.frame_err = any_err;
          next_r.out_err = any_err;
        end
      end
      MPFI_TX_FRAME:
      begin
        if (r.held_valid)
        begin
          next_r.out_byte = r.held_byte;
          next_r.out_valid = 1'b1;
          next_r.out_err = r.frame_err;
          // The word offered now is dropped, but its error still counts
          next_r.frame_err = r.frame_err | any_err;
        end
        else if (vld[0])
        begin
          next_r.out_byte = link.wide_tx_bytes[`MPFI_LO_MSB:0];
          next_r.out_valid = 1'b1;
          next_r.frame_err = r.frame_err | any_err;
          next_r.out_err = r.frame_err | any_err;
        end
        if (!vld[0] && !r.held_valid)
        begin
          next_r.st = MPFI_TX_IDLE;
          next_r.out_end = 1'b1;
        end
      end
      default: next_r.st = MPFI_TX_IDLE;
    endcase

    // Capture the upper lane when the lower one is consumed
    if (!r.held_valid && vld[0] && vld[1])
    begin
      next_r.held_byte = link.wide_tx_bytes[`MPFI_DATA_W-1:`MPFI_HI_LSB];
      next_r.held_valid = 1'b1;
    end
    else
      next_r.held_valid = 1'b0;

    // Bytes sent across a rate switch are suspect, so the frame is marked
    if (r.st == MPFI_TX_FRAME && next_r.speed != r.speed)
    begin
      next_r.frame_err = 1'b1;
      next_r.out_err = next_r.out_valid;
    end

    // Receive side is up only while neither receive reset is held
    next_r.rx_act = !link.rx_digital_reset && !link.rx_analog_reset;

    // A transmit reset drops the frame in flight; a cut frame is still closed
    if (link.tx_digital_reset || link.tx_analog_reset)
    begin
      next_r.st = MPFI_TX_IDLE;
      next_r.held_valid = 1'b0;
      next_r.out_valid = 1'b0;
      next_r.out_err = 1'b0;
      next_r.out_start = 1'b0;
      next_r.out_end = (r.st == MPFI_TX_FRAME);
      next_r.frame_err = 1'b0;
    end
    if (link.rx_digital_reset || link.rx_analog_reset)
      next_r.rx_act = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered on the transmit parallel clock
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r <= '0;
      r.delay <= PATH_DELAY;
      r.tx_an_stat <= 1'b1;
      r.tx_dig_stat <= 1'b1;
      r.rx_an_stat <= 1'b1;
      r.rx_dig_stat <= 1'b1;
      r.speed <= `MPFI_SPD_1G;
      r.st <= MPFI_TX_IDLE;
    end
    else
      r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.tx_analog_reset_stat = r.tx_an_stat;
  assign link.tx_digital_reset_stat = r.tx_dig_stat;
  assign link.rx_analog_reset_stat = r.rx_an_stat;
  assign link.rx_digital_reset_stat = r.rx_dig_stat;
  assign link.operating_speed = r.speed;
  assign link.wide_tx_path_delay = r.delay;
  assign line_byte = r.out_byte;
  assign line_byte_valid = r.out_valid;
  assign line_byte_error = r.out_err;
  assign line_frame_start = r.out_start;
  assign line_frame_end = r.out_end;
  assign rx_active = r.rx_act;

endmodule

// >>> mpfi_host.sv
`timescale 1ns/100ps
`include "mpfi_params.svh"
module mpfi_host
  import mpfi_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link to device
  mpfi_if.host link,
  // User reset and rate requests
  input wire logic req_tx_analog_reset,
  input wire logic req_tx_digital_reset,
  input wire logic req_rx_analog_reset,
  input wire logic req_rx_digital_reset,
  input wire logic [1:0] req_speed_sel,
  // User transmit stream, one 16-bit word per cycle
  input wire logic [15:0] user_bytes,
  input wire logic [1:0] user_lane_valid,
  input wire logic [1:0] user_lane_error,
  // Device state seen by the user
  output logic [3:0] reset_stat,
  output logic [2:0] speed_now,
  output logic [21:0] path_delay
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [3:0] rst_req;
    logic [1:0] sel;
    mpfi_bytes_t bytes;
    logic [1:0] valid;
    logic [1:0] err;
    logic [3:0] stat;
    logic [2:0] spd;
    logic [21:0] dly;
  } mpfi_host_s;

  mpfi_host_s r;
  mpfi_host_s next_r;

  always_comb
  begin
    next_r = r;
    next_r.rst_req = {req_rx_digital_reset, req_rx_analog_reset, req_tx_digital_reset, req_tx_analog_reset};
    if (req_speed_sel != `MPFI_XCVR_BAD)
      next_r.sel = req_speed_sel;
    next_r.bytes = user_bytes;
    next_r.valid = user_lane_valid;
    next_r.err = user_lane_error & user_lane_valid;
    next_r.stat = {link.rx_digital_reset_stat, link.rx_analog_reset_stat,
      link.tx_digital_reset_stat, link.tx_analog_reset_stat};
    next_r.spd = link.operating_speed;
    next_r.dly = link.wide_tx_path_delay;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r <= '0;
      r.rst_req <= 4'hF;
    end
    else
      r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.tx_analog_reset = r.rst_req[0];
  assign link.tx_digital_reset = r.rst_req[1];
  assign link.rx_analog_reset = r.rst_req[2];
  assign link.rx_digital_reset = r.rst_req[3];
  assign link.xcvr_speed_sel = r.sel;
  assign link.wide_tx_bytes = r.bytes;
  assign link.wide_tx_lane_valid = r.valid;
  assign link.wide_tx_lane_error = r.err;
  assign reset_stat = r.stat;
  assign speed_now = r.spd;
  assign path_delay = r.dly;

endmodule

// >>> mpfi_chk.sv
`timescale 1ns/100ps
module mpfi_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Reset requests and status
  input wire logic tx_analog_reset,
  input wire logic tx_digital_reset,
  input wire logic rx_analog_reset,
  input wire logic rx_digital_reset,
  input wire logic tx_analog_reset_stat,
  input wire logic tx_digital_reset_stat,
  input wire logic rx_analog_reset_stat,
  input wire logic rx_digital_reset_stat,
  // Rate and delay
  input wire logic [1:0] xcvr_speed_sel,
  input wire logic [2:0] operating_speed,
  input wire logic [21:0] wide_tx_path_delay
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence held_reset;
    reset ##1 reset;
  endsequence
  property reset_clears;
    disable iff (1'b0) held_reset |-> operating_speed == 3'h1 && tx_analog_reset_stat && rx_digital_reset_stat;
  endproperty
  ////////////////////////////////////////////////////////////////
  reset_state_a: assert property (reset_clears) else $error("reset state wrong");
  txa_stat_a: assert property (tx_analog_reset_stat == $past(tx_analog_reset)) else $error("tx analog stat");
  txd_stat_a: assert property (tx_digital_reset_stat == $past(tx_digital_reset)) else $error("tx digital stat");
  rxa_stat_a: assert property (rx_analog_reset_stat == $past(rx_analog_reset)) else $error("rx analog stat");
  rxd_stat_a: assert property (rx_digital_reset_stat == $past(rx_digital_reset)) else $error("rx digital stat");
  rate_10g_a: assert property (xcvr_speed_sel == 2'h3 |=> operating_speed == 3'h0) else $error("10G code");
  rate_1g_a: assert property (xcvr_speed_sel == 2'h0 |=> operating_speed == 3'h1) else $error("1G code");
  rate_2p5g_a: assert property (xcvr_speed_sel == 2'h1 |=> operating_speed == 3'h4) else $error("2.5G code");
  path_delay_a: assert property (wide_tx_path_delay == 22'h000800) else $error("path delay");
  legal_sel_a: assert property (xcvr_speed_sel != 2'h2) else $error("unlisted speed code driven");
endmodule

// >>> mpfi_test.sv
`timescale 1ns/100ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module mpfi_test;
  import mpfi_pkg::*;
  typedef struct packed {logic [3:0] req; logic [1:0] sel; logic [2:0] spd;} mpfi_row_s;
  localparam mpfi_row_s ROWS [6] = '{'{4'h0, 2'h0, 3'h1}, '{4'h1, 2'h3, 3'h0}, '{4'h2, 2'h1, 3'h4},
    '{4'h4, 2'h2, 3'h4}, '{4'h8, 2'h0, 3'h1}, '{4'hF, 2'h3, 3'h0}};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] req = 4'h0;
  logic [1:0] sel = 2'h0;
  logic [1:0] uv = 2'h0;
  logic [1:0] ue = 2'h0;
  logic [15:0] ub = 16'h0000;
  logic [3:0] reset_stat;
  logic [2:0] speed_now;
  logic [21:0] path_delay;
  logic [7:0] lb;
  logic lbv, lbe, lfs, lfe, rx_active;
  logic [8:0] got[$];
  logic [7:0] exp_b [6] = '{8'hAA, 8'hBB, 8'hCC, 8'hDD, 8'hEE, 8'h11};
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int starts = 0;
  int ends = 0;
  mpfi_if lk();
  mpfi_device i_mpfi_device (.clk(clk), .reset(reset), .link(lk.device), .line_byte(lb), .line_byte_valid(lbv),
    .line_byte_error(lbe), .line_frame_start(lfs), .line_frame_end(lfe), .rx_active(rx_active));
  mpfi_host i_mpfi_host (.clk(clk), .reset(reset), .link(lk.host), .req_tx_analog_reset(req[0]),
    .req_tx_digital_reset(req[1]), .req_rx_analog_reset(req[2]), .req_rx_digital_reset(req[3]),
    .req_speed_sel(sel), .user_bytes(ub), .user_lane_valid(uv), .user_lane_error(ue),
    .reset_stat(reset_stat), .speed_now(speed_now), .path_delay(path_delay));
  mpfi_chk i_mpfi_chk (.clk(clk), .reset(reset), .tx_analog_reset(lk.tx_analog_reset),
    .tx_digital_reset(lk.tx_digital_reset), .rx_analog_reset(lk.rx_analog_reset),
    .rx_digital_reset(lk.rx_digital_reset), .tx_analog_reset_stat(lk.tx_analog_reset_stat),
    .tx_digital_reset_stat(lk.tx_digital_reset_stat), .rx_analog_reset_stat(lk.rx_analog_reset_stat),
    .rx_digital_reset_stat(lk.rx_digital_reset_stat), .xcvr_speed_sel(lk.xcvr_speed_sel),
    .operating_speed(lk.operating_speed), .wide_tx_path_delay(lk.wide_tx_path_delay));
  ////////////////////////////////////////////////////////////////
  task check(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task word(input logic [15:0] b, input logic [1:0] v, input logic [1:0] e);
    @(negedge clk);
    ub = b;
    uv = v;
    ue = e;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Line byte monitor and hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (lbv === 1'b1)
      got.push_back({lbe, lb});
    starts += int'(lfs);
    ends += int'(lfe);
    if (cycles == 1000)
    begin
      failures++;
      conclude();
    end
  end
  initial
  begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    foreach (ROWS[i])
    begin
      @(negedge clk);
      req = ROWS[i].req;
      sel = ROWS[i].sel;
      repeat (4) @(negedge clk);
      `CHK("reset_stat", ROWS[i].req, reset_stat);
      `CHK("speed_now", ROWS[i].spd, speed_now);
      `CHK("rx_active", ~|ROWS[i].req[3:2], rx_active);
    end
    $display("rate and reset table done");
    req = 4'h0;
    repeat (4) @(negedge clk);
    got.delete();
    word(16'hBBAA, 2'h3, 2'h0);
    word(16'hBBAA, 2'h3, 2'h0);
    word(16'hDDCC, 2'h3, 2'h2);
    word(16'hDDCC, 2'h3, 2'h2);
    word(16'h00EE, 2'h1, 2'h0);
    word(16'h0000, 2'h0, 2'h0);
    word(16'h0011, 2'h1, 2'h0);
    word(16'h0000, 2'h0, 2'h0);
    repeat (6) @(negedge clk);
    `CHK("byte_count", 6, got.size());
    foreach (exp_b[i])
      `CHK("line_byte", exp_b[i], got[i][7:0]);
    `CHK("first_err", 1'b0, got[0][8]);
    `CHK("last_err", 1'b1, got[4][8]);
    `CHK("next_frame_err", 1'b0, got[5][8]);
    `CHK("starts", 2, starts);
    `CHK("ends", 2, ends);
    `CHK("path_delay", 22'h000800, path_delay);
    $display("frame test done");
    word(16'h6655, 2'h3, 2'h0);
    word(16'h6655, 2'h3, 2'h0);
    req = 4'h2;
    word(16'h0000, 2'h0, 2'h0);
    req = 4'h0;
    repeat (4) @(negedge clk);
    `CHK("cut_bytes", 7, got.size());
    `CHK("cut_byte", 8'h55, got[6][7:0]);
    `CHK("cut_starts", 3, starts);
    `CHK("cut_ends", 3, ends);
    $display("cut frame test done");
    reset = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("reset_speed", 3'h1, lk.operating_speed);
    `CHK("reset_valid", 1'b0, lbv);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("reset_stat_after", 4'h0, reset_stat);
    `CHK("speed_after", 3'h0, speed_now);
    $display("mid run reset done");
    conclude();
  end
endmodule
